// ### adg_pkg.sv
// package: constants and types of the absolute and direct address generator
package adg_pkg;
   localparam int ADG_DATA_AW = 23;
   localparam int ADG_IO_AW   = 16;
   localparam int ADG_PAGE_W  = 7;
   localparam int ADG_PTR_W   = 16;
   localparam int ADG_OFF_W   = 7;
   localparam int ADG_PERI_W  = 9;
   localparam int ADG_EXT_W   = 24;
   localparam int ADG_APB_AW  = 8;
   localparam int ADG_CNT_W   = 8;

   // register byte offsets
   localparam logic [7:0] ADG_OFS_DPH  = 8'h00;
   localparam logic [7:0] ADG_OFS_DP   = 8'h04;
   localparam logic [7:0] ADG_OFS_XDP  = 8'h08;
   localparam logic [7:0] ADG_OFS_SPH  = 8'h0c;
   localparam logic [7:0] ADG_OFS_SP   = 8'h10;
   localparam logic [7:0] ADG_OFS_PDP  = 8'h14;
   localparam logic [7:0] ADG_OFS_ST1  = 8'h18;
   localparam logic [7:0] ADG_OFS_LAST = 8'h1c;
   localparam logic [7:0] ADG_OFS_REFC = 8'h20;

   // field positions
   localparam int ADG_ST1_CPL_BIT  = 0;
   localparam int ADG_LAST_IO_BIT  = 23;
   localparam int ADG_LAST_BIT_BIT = 24;

   // reset values
   localparam logic [6:0]  ADG_RST_DPH = 7'h00;
   localparam logic [15:0] ADG_RST_DP  = 16'h0000;
   localparam logic [6:0]  ADG_RST_SPH = 7'h00;
   localparam logic [15:0] ADG_RST_SP  = 16'h0000;
   localparam logic [8:0]  ADG_RST_PDP = 9'h000;
   localparam logic        ADG_RST_CPL = 1'b0;

   typedef enum logic [2:0] {
      ADG_MODE_K16,
      ADG_MODE_K23,
      ADG_MODE_IO_ABS,
      ADG_MODE_DIRECT,
      ADG_MODE_REG_BIT,
      ADG_MODE_PDP
   } adg_mode_t;
endpackage

// ### adg_calc_if.sv
// interface: page state and operand in, formed address out
`timescale 1ns/1ps
`default_nettype none
interface adg_calc_if;
   import adg_pkg::*;
   adg_mode_t          mode;
   logic [23:0]        ext;
   logic [6:0]         offset;
   logic               mmr_qual;
   logic               direct_mode_select;
   logic [6:0]         data_page_high;
   logic [15:0]        dp;
   logic [6:0]         stack_page_high;
   logic [15:0]        sp;
   logic [8:0]         peripheral_page_register;
   logic [22:0]        addr;
   logic               is_io;
   logic               is_bit;
   modport regs (output mode, ext, offset, mmr_qual, direct_mode_select, data_page_high, dp, stack_page_high, sp,
                 peripheral_page_register, input addr, is_io, is_bit);
   modport calc (input mode, ext, offset, mmr_qual, direct_mode_select, data_page_high, dp, stack_page_high, sp,
                 peripheral_page_register, output addr, is_io, is_bit);
endinterface
`default_nettype wire

// ### adg_addr_calc.sv
// module: combinational address former for absolute and direct modes
`timescale 1ns/1ps
`default_nettype none
module adg_addr_calc
(
   adg_calc_if.calc c
);
   import adg_pkg::*;

   logic [15:0] dp_eff;
   logic [6:0]  dph_eff;

   // register-space qualifier acts as zero page and zero pointer
   always_comb
   begin
      dp_eff  = c.mmr_qual ? 16'h0000 : c.dp;
      dph_eff = c.mmr_qual ? 7'h00 : c.data_page_high;
   end

   always_comb
   begin
      c.addr   = 23'h000000;
      c.is_io  = 1'b0;
      c.is_bit = 1'b0;
      case (c.mode)
         ADG_MODE_K16:
            c.addr = {c.data_page_high, c.ext[15:0]};
         ADG_MODE_K23:
            c.addr = c.ext[22:0];
         ADG_MODE_IO_ABS:
         begin
            c.addr  = {7'h00, c.ext[15:0]};
            c.is_io = 1'b1;
         end
         ADG_MODE_DIRECT:
            // 16-bit sum truncates: wraps inside the main page
            if (c.direct_mode_select)
               c.addr = {c.stack_page_high, 16'(c.sp + {9'h000, c.offset})};
            else
               c.addr = {dph_eff, 16'(dp_eff + {9'h000, c.offset})};
         ADG_MODE_REG_BIT:
         begin
            c.addr   = {16'h0000, c.offset};
            c.is_bit = 1'b1;
         end
         ADG_MODE_PDP:
         begin
            c.addr  = {7'h00, c.peripheral_page_register, c.offset};
            c.is_io = 1'b1;
         end
         default:
            c.addr = 23'h000000;
      endcase
   end
endmodule // adg_addr_calc
`default_nettype wire

// ### adg_top.sv
// module: address generator top with page registers over apb
//
// Contract
// - short constant mode joins high page and constant
// - constant comes from two or three extension bytes
// - long constant mode drops extension top bit
// - absolute modes never issued when paired
// - io absolute uses constant unchanged
// - select bit picks page or stack direct
// - bit and peripheral direct ignore select bit
// - page direct upper bits from high page
// - page direct low bits pointer plus offset
// - page pointer takes any start address
// - page halves writable apart and together
// - direct low sum wraps inside page
// - stack direct uses stack page and pointer
// - bit direct offset is register bit address
// - peripheral direct uses page register and offset
// - register-space qualifier changes offset use
// - qualifier forces page and pointer to zero
// - stack direct adds unsigned seven-bit offset
// - peripheral page gives upper nine bits
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module adg_top
(
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output var  logic [31:0]            prdata,
   output var  logic                   pready,
   output var  logic                   pslverr,
   input  wire logic                   op_valid,
   input  wire adg_pkg::adg_mode_t     op_mode,
   input  wire logic [23:0]            op_ext,
   input  wire logic [6:0]             op_offset,
   input  wire logic                   op_mmr_qual,
   input  wire logic                   op_bit_pair,
   input  wire logic                   op_paired,
   output var  logic                   addr_valid,
   output var  logic [22:0]            addr_out,
   output var  logic                   addr_is_io,
   output var  logic                   addr_is_bit,
   output var  logic                   addr_bit_pair,
   output var  logic                   pair_refused
);
   import adg_pkg::*;

   logic [6:0]   dph_reg;
   logic [15:0]  dp_reg;
   logic [6:0]   sph_reg;
   logic [15:0]  sp_reg;
   logic [8:0]   pdp_reg;
   logic         cpl_reg;
   logic [7:0]   refused_cnt_reg;
   logic [31:0]  rdata_next;
   logic         rerr_next;
   logic         wr_take;
   logic         setup;
   logic         is_abs;
   logic         refuse;
   logic         accept;

   adg_calc_if calc_bus ();

   function automatic logic mode_is_abs(input adg_mode_t m);
      return (m == ADG_MODE_K16) || (m == ADG_MODE_K23) ||
             (m == ADG_MODE_IO_ABS);
   endfunction

   function automatic logic addr_mapped(input logic [7:0] a);
      return (a == ADG_OFS_DPH) || (a == ADG_OFS_DP) ||
             (a == ADG_OFS_XDP) || (a == ADG_OFS_SPH) ||
             (a == ADG_OFS_SP) || (a == ADG_OFS_PDP) ||
             (a == ADG_OFS_ST1) || (a == ADG_OFS_LAST) ||
             (a == ADG_OFS_REFC);
   endfunction

   function automatic logic addr_read_only(input logic [7:0] a);
      return (a == ADG_OFS_LAST) || (a == ADG_OFS_REFC);
   endfunction

   assign setup   = psel && !penable;
   assign wr_take = psel && penable && pready && pwrite && !pslverr;
   assign is_abs  = mode_is_abs(op_mode);
   // the extension word fills the pairing slot
   assign refuse  = op_valid && is_abs && op_paired;
   assign accept  = op_valid && !refuse;

   // operand path into the address former
   assign calc_bus.mode     = op_mode;
   assign calc_bus.ext      = op_ext;
   assign calc_bus.offset   = op_offset;
   assign calc_bus.mmr_qual = op_mmr_qual;
   assign calc_bus.direct_mode_select      = cpl_reg;
   assign calc_bus.data_page_high      = dph_reg;
   assign calc_bus.dp       = dp_reg;
   assign calc_bus.stack_page_high      = sph_reg;
   assign calc_bus.sp       = sp_reg;
   assign calc_bus.peripheral_page_register      = pdp_reg;

   adg_addr_calc u_calc
   (
      .c (calc_bus.calc)
   );

   // apb: answer prepared in setup, pready high in the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready <= 1'b0;
      else
         pready <= setup;
   end

   always_comb
   begin
      rdata_next = 32'h00000000;
      rerr_next  = 1'b0;
      if (!addr_mapped(paddr))
         rerr_next = 1'b1;
      else if (pwrite && addr_read_only(paddr))
         rerr_next = 1'b1;
      else if (paddr == ADG_OFS_DPH)
         rdata_next = {25'h0000000, dph_reg};
      else if (paddr == ADG_OFS_DP)
         rdata_next = {16'h0000, dp_reg};
      else if (paddr == ADG_OFS_XDP)
         rdata_next = {9'h000, dph_reg, dp_reg};
      else if (paddr == ADG_OFS_SPH)
         rdata_next = {25'h0000000, sph_reg};
      else if (paddr == ADG_OFS_SP)
         rdata_next = {16'h0000, sp_reg};
      else if (paddr == ADG_OFS_PDP)
         rdata_next = {23'h000000, pdp_reg};
      else if (paddr == ADG_OFS_ST1)
         rdata_next = {31'h00000000, cpl_reg};
      else if (paddr == ADG_OFS_LAST)
         rdata_next = {7'h00, addr_is_bit, addr_is_io, addr_out};
      else
         rdata_next = {24'h000000, refused_cnt_reg};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         prdata  <= pwrite ? 32'h00000000 : rdata_next;
         pslverr <= rerr_next;
      end
      else if (!psel)
      begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
   end

   // data page: halves apart or both at once
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dph_reg <= ADG_RST_DPH;
         dp_reg  <= ADG_RST_DP;
      end
      else if (wr_take)
      begin
         if (paddr == ADG_OFS_DPH)
            dph_reg <= pwdata[6:0];
         else if (paddr == ADG_OFS_DP)
            dp_reg <= pwdata[15:0];
         else if (paddr == ADG_OFS_XDP)
         begin
            dph_reg <= pwdata[22:16];
            dp_reg  <= pwdata[15:0];
         end
      end
   end

   // stack page and pointer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sph_reg <= ADG_RST_SPH;
         sp_reg  <= ADG_RST_SP;
      end
      else if (wr_take)
      begin
         if (paddr == ADG_OFS_SPH)
            sph_reg <= pwdata[6:0];
         else if (paddr == ADG_OFS_SP)
            sp_reg <= pwdata[15:0];
      end
   end

   // peripheral page and direct mode select
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pdp_reg <= ADG_RST_PDP;
         cpl_reg <= ADG_RST_CPL;
      end
      else if (wr_take)
      begin
         if (paddr == ADG_OFS_PDP)
            pdp_reg <= pwdata[8:0];
         else if (paddr == ADG_OFS_ST1)
            cpl_reg <= pwdata[ADG_ST1_CPL_BIT];
      end
   end

   // one registered stage toward the access stage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         addr_valid    <= 1'b0;
         addr_out      <= 23'h000000;
         addr_is_io    <= 1'b0;
         addr_is_bit   <= 1'b0;
         addr_bit_pair <= 1'b0;
      end
      else
      begin
         addr_valid <= accept;
         if (accept)
         begin
            addr_out      <= calc_bus.addr;
            addr_is_io    <= calc_bus.is_io;
            addr_is_bit   <= calc_bus.is_bit;
            // two adjacent bits only mean something in bit mode
            addr_bit_pair <= calc_bus.is_bit && op_bit_pair;
         end
      end
   end

   // refusal pulse and a saturating count for software
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pair_refused    <= 1'b0;
         refused_cnt_reg <= 8'h00;
      end
      else
      begin
         pair_refused <= refuse;
         if (refuse && refused_cnt_reg != 8'hff)
            refused_cnt_reg <= refused_cnt_reg + 8'h01;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_k16_concat: assert property (
      accept && op_mode == ADG_MODE_K16 |=>
         addr_valid && addr_out == {$past(dph_reg), $past(op_ext[15:0])})
      else $error("k16 address not page and constant");

   chk_k23_drop_msb: assert property (
      accept && op_mode == ADG_MODE_K23 |=>
         addr_out == $past(op_ext[22:0]) && !addr_is_io)
      else $error("k23 address not low 23 extension bits");

   chk_abs_paired: assert property (
      op_valid && mode_is_abs(op_mode) && op_paired |=>
         !addr_valid && pair_refused)
      else $error("paired absolute operand was issued");

   chk_io_abs: assert property (
      accept && op_mode == ADG_MODE_IO_ABS |=>
         addr_is_io && addr_out[15:0] == $past(op_ext[15:0]))
      else $error("io absolute address altered");

   chk_dp_direct: assert property (
      accept && op_mode == ADG_MODE_DIRECT && !cpl_reg && !op_mmr_qual |=>
         addr_out == {$past(dph_reg),
                      16'($past(dp_reg) + {9'h000, $past(op_offset)})})
      else $error("page direct address wrong");

   chk_sp_direct: assert property (
      accept && op_mode == ADG_MODE_DIRECT && cpl_reg |=>
         addr_out == {$past(sph_reg),
                      16'($past(sp_reg) + {9'h000, $past(op_offset)})})
      else $error("stack direct address wrong");

   chk_mmr_zero_page: assert property (
      accept && op_mode == ADG_MODE_DIRECT && !cpl_reg && op_mmr_qual |=>
         addr_out == {16'h0000, $past(op_offset)})
      else $error("qualified page direct not on page zero");

   chk_pdp_direct: assert property (
      accept && op_mode == ADG_MODE_PDP |=>
         addr_is_io && addr_out == {7'h00, $past(pdp_reg), $past(op_offset)})
      else $error("peripheral direct address wrong");

   chk_bit_direct: assert property (
      accept && op_mode == ADG_MODE_REG_BIT |=>
         addr_is_bit && !addr_is_io && addr_out == {16'h0000, $past(op_offset)})
      else $error("bit direct address wrong");

   chk_xdp_load: assert property (
      wr_take && paddr == ADG_OFS_XDP |=>
         {dph_reg, dp_reg} == $past(pwdata[22:0]))
      else $error("extended page load lost a half");

   chk_apb_ready: assert property (
      psel && !penable |=> pready ##1 !pready)
      else $error("apb answer not exactly one access cycle");

   chk_high_alone: assert property (
      wr_take && paddr == ADG_OFS_DPH |=>
         dph_reg == $past(pwdata[6:0]) && $stable(dp_reg))
      else $error("high page write disturbed the pointer");

   chk_ptr_alone: assert property (
      wr_take && paddr == ADG_OFS_DP |=>
         dp_reg == $past(pwdata[15:0]) && $stable(dph_reg))
      else $error("pointer write lost or disturbed the high page");

   chk_refuse_holds: assert property (
      refuse |=> $stable(addr_out) && $stable(addr_is_io))
      else $error("refused operand changed the delivered address");

   chk_space_flag: assert property (
      accept |=> addr_valid &&
         addr_is_io == ($past(op_mode) == ADG_MODE_IO_ABS ||
                        $past(op_mode) == ADG_MODE_PDP))
      else $error("space flag does not match operand mode");

   cov_k16:     cover property (accept && op_mode == ADG_MODE_K16);
   cov_sp_wrap: cover property (accept && op_mode == ADG_MODE_DIRECT &&
                                cpl_reg && sp_reg == 16'hffff &&
                                op_offset != 7'h00);
   cov_refuse:  cover property (refuse);
   cov_xdp_wr:  cover property (wr_take && paddr == ADG_OFS_XDP);
   cov_bit_two: cover property (accept && op_mode == ADG_MODE_REG_BIT &&
                                op_bit_pair);
endmodule // adg_top
`default_nettype wire

// ### adg_access_sink.sv
// model: access stage that takes each delivered operand address
`timescale 1ns/1ps
`default_nettype none
module adg_access_sink
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        addr_valid,
   input  wire logic [22:0] addr_out,
   input  wire logic        addr_is_io,
   input  wire logic        addr_is_bit,
   output var  logic [22:0] seen_addr,
   output var  logic        seen_io,
   output var  logic        seen_bit,
   output var  logic [7:0]  seen_cnt
);
   // takes the address only in its flagged cycle, never a stale one
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         seen_addr <= '0;
         seen_io   <= 1'b0;
         seen_bit  <= 1'b0;
         seen_cnt  <= '0;
      end
      else if (addr_valid)
      begin
         seen_addr <= addr_out;
         seen_io   <= addr_is_io;
         seen_bit  <= addr_is_bit;
         seen_cnt  <= seen_cnt + 8'h01;
      end
   end
endmodule // adg_access_sink
`default_nettype wire

// ### adg_top_bench.sv
// testbench: address generator top driven over apb and operand requests
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
   begin \
      total_checks++; \
      if ((a) !== (b)) \
      begin \
         miscompares++; \
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); \
      end \
   end
module adg_top_bench;
   import adg_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd_data;
   logic        pready, pslverr, rd_err;
   logic        op_valid, op_mmr_qual, op_bit_pair, op_paired;
   adg_mode_t   op_mode;
   logic [23:0] op_ext;
   logic [6:0]  op_offset;
   logic        addr_valid, addr_is_io, addr_is_bit;
   logic        addr_bit_pair, pair_refused, got_v, got_r;
   logic [22:0] addr_out, got_a, seen_addr;
   logic        seen_io, seen_bit;
   logic [7:0]  seen_cnt, exp_cnt;
   int          miscompares, total_checks, cycles;

   adg_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .op_valid(op_valid), .op_mode(op_mode), .op_ext(op_ext),
      .op_offset(op_offset), .op_mmr_qual(op_mmr_qual),
      .op_bit_pair(op_bit_pair), .op_paired(op_paired),
      .addr_valid(addr_valid), .addr_out(addr_out),
      .addr_is_io(addr_is_io), .addr_is_bit(addr_is_bit),
      .addr_bit_pair(addr_bit_pair), .pair_refused(pair_refused));
   adg_access_sink i_sink (.pclk(pclk), .presetn(presetn),
      .addr_valid(addr_valid), .addr_out(addr_out),
      .addr_is_io(addr_is_io), .addr_is_bit(addr_is_bit),
      .seen_addr(seen_addr), .seen_io(seen_io), .seen_bit(seen_bit),
      .seen_cnt(seen_cnt));

   always #10 pclk = ~pclk;

   task automatic report_and_stop();
      if (miscompares == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // whole run needs well under a thousand cycles
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         report_and_stop();
      end
   end

   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // slave picks the wait; only the bench timeout ends it
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      // values read here are those sampled by this edge
      rd_data = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // idle edge so a following call never reassigns in this step
      @(posedge pclk);
   endtask

   task automatic op(input adg_mode_t m, input logic [23:0] x,
      input logic [6:0] o, input logic q, input logic bp, input logic pr);
      op_valid    <= 1'b1;
      op_mode     <= m;
      op_ext      <= x;
      op_offset   <= o;
      op_mmr_qual <= q;
      op_bit_pair <= bp;
      op_paired   <= pr;
      @(posedge pclk);
      op_valid <= 1'b0;
      #1;
      got_v = addr_valid;
      got_r = pair_refused;
      got_a = addr_out;
      @(posedge pclk);
   endtask

   task automatic run(input adg_mode_t m, input logic [23:0] x,
      input logic [6:0] o, input logic q, input logic bp,
      input logic [22:0] ea, input logic ei, input logic eb);
      op(m, x, o, q, bp, 1'b0);
      exp_cnt++;
      #1;
      `CHK(got_v, 1'b1)
      `CHK(seen_addr, ea)
      `CHK(seen_io, ei)
      `CHK(seen_bit, eb)
      @(posedge pclk);
   endtask

   task automatic t_regs();
      for (int a = 0; a <= 32; a += 4)
      begin
         apb(1'b0, 8'(a), 32'h0);
         `CHK(rd_data, 32'h0)
         `CHK(rd_err, 1'b0)
      end
      apb(1'b0, 8'h24, 32'h0);
      `CHK(rd_err, 1'b1)
      apb(1'b1, ADG_OFS_XDP, 32'h03fff0);
      apb(1'b0, ADG_OFS_DPH, 32'h0);
      `CHK(rd_data, 32'h03)
      apb(1'b1, ADG_OFS_DP, 32'h1235);
      apb(1'b0, ADG_OFS_XDP, 32'h0);
      `CHK(rd_data, 32'h031235)
   endtask

   task automatic t_abs();
      apb(1'b1, ADG_OFS_DPH, 32'h55);
      run(ADG_MODE_K16, 24'hab1234, 7'h0, 0, 0, 23'h551234, 0, 0);
      run(ADG_MODE_K23, 24'hffffff, 7'h0, 0, 0, 23'h7fffff, 0, 0);
      run(ADG_MODE_K23, 24'h012345, 7'h0, 0, 0, 23'h012345, 0, 0);
      run(ADG_MODE_IO_ABS, 24'hffbeef, 7'h0, 0, 0, 23'hbeef, 1, 0);
   endtask

   task automatic t_pair();
      adg_mode_t ms[3];
      ms = '{ADG_MODE_K16, ADG_MODE_K23, ADG_MODE_IO_ABS};
      foreach (ms[i])
      begin
         op(ms[i], 24'h123456, 7'h0, 1'b0, 1'b0, 1'b1);
         `CHK(got_v, 1'b0)
         `CHK(got_r, 1'b1)
         `CHK(got_a, 23'h00beef)
      end
      apb(1'b0, ADG_OFS_REFC, 32'h0);
      `CHK(rd_data, 32'h3)
   endtask

   task automatic t_direct();
      apb(1'b1, ADG_OFS_XDP, 32'h03fff0);
      apb(1'b1, ADG_OFS_ST1, 32'h0);
      run(ADG_MODE_DIRECT, 24'h0, 7'h04, 0, 0, 23'h03fff4, 0, 0);
      run(ADG_MODE_DIRECT, 24'h0, 7'h7f, 0, 0, 23'h03006f, 0, 0);
      run(ADG_MODE_DIRECT, 24'h0, 7'h10, 1, 0, 23'h000010, 0, 0);
      apb(1'b1, ADG_OFS_SPH, 32'h12);
      apb(1'b1, ADG_OFS_SP, 32'hffff);
      apb(1'b1, ADG_OFS_ST1, 32'h1);
      run(ADG_MODE_DIRECT, 24'h0, 7'h7f, 0, 0, 23'h12007e, 0, 0);
      run(ADG_MODE_DIRECT, 24'h0, 7'h00, 1, 0, 23'h12ffff, 0, 0);
   endtask

   task automatic t_bit_peri();
      apb(1'b1, ADG_OFS_PDP, 32'h1ff);
      for (int s = 0; s < 2; s++)
      begin
         apb(1'b1, ADG_OFS_ST1, 32'(s));
         run(ADG_MODE_REG_BIT, 24'h0, 7'h05, 0, 1, 23'h5, 0, 1);
         `CHK(addr_bit_pair, 1'b1)
         run(ADG_MODE_PDP, 24'h0, 7'h7f, 0, 1, 23'hffff, 1, 0);
         `CHK(addr_bit_pair, 1'b0)
      end
      apb(1'b1, ADG_OFS_PDP, 32'h002);
      run(ADG_MODE_PDP, 24'h0, 7'h01, 0, 0, 23'h0101, 1, 0);
   endtask

   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, op_valid} = '0;
      {op_mmr_qual, op_bit_pair, op_paired} = '0;
      paddr = '0;
      pwdata = '0;
      op_mode = ADG_MODE_K16;
      op_ext = '0;
      op_offset = '0;
      exp_cnt = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_abs();
      t_pair();
      t_direct();
      t_bit_peri();
      `CHK(seen_cnt, exp_cnt)
      report_and_stop();
   end
endmodule // adg_top_bench
`default_nettype wire
